/* File: hdl/afc_pkg.sv */
// Purpose: Shared constants for the automatic receive flow controller.
// Assumes: 250 MHz system clock, APB register access with 32-bit data.
// Notes: Durations are kept in nanoseconds and converted to cycles here.
package afc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam logic [11:0] AUTO_FLOW_CONFIG_OFFSET = 12'h0AC;
  localparam logic [11:0] AFC_STATUS_OFFSET = 12'h0B4;
  localparam int unsigned HIGH_MSB = 23;
  localparam int unsigned HIGH_LSB = 16;
  localparam int unsigned LOW_MSB = 15;
  localparam int unsigned LOW_LSB = 8;
  localparam int unsigned DUR_MSB = 7;
  localparam int unsigned DUR_LSB = 4;
  localparam int unsigned MCAST_BIT = 3;
  localparam int unsigned BCAST_BIT = 2;
  localparam int unsigned OWN_BIT = 1;
  localparam int unsigned ANY_BIT = 0;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_WRITE_MASK = 32'h00FF_FFFF;
  localparam int unsigned LEVEL_UNIT_BYTES = 64;
  // Jam durations at 100 Mb/s in nanoseconds, codes 0h to Fh.
  localparam int unsigned JAM_NS_0 = 5000;
  localparam int unsigned JAM_NS_1 = 10000;
  localparam int unsigned JAM_NS_2 = 15000;
  localparam int unsigned JAM_NS_3 = 25000;
  localparam int unsigned JAM_STEP_NS = 50000;
  localparam int unsigned JAM_SLOW_EXTRA_NS = 2200;
  localparam int unsigned JAM_CYC_0 = JAM_NS_0 / CLK_PERIOD_NS;
  localparam int unsigned JAM_CYC_1 = JAM_NS_1 / CLK_PERIOD_NS;
  localparam int unsigned JAM_CYC_2 = JAM_NS_2 / CLK_PERIOD_NS;
  localparam int unsigned JAM_CYC_3 = JAM_NS_3 / CLK_PERIOD_NS;
  localparam int unsigned JAM_STEP_CYC = JAM_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned JAM_SLOW_CYC = JAM_SLOW_EXTRA_NS / CLK_PERIOD_NS;
  localparam int unsigned JAM_CNT_W = 18;
  typedef enum logic [2:0] {
    AFC_IDLE = 3'b001,
    AFC_HELD = 3'b010,
    AFC_RELEASE = 3'b100
  } afc_state_type;
endpackage

/* File: hdl/afc_jam_timer.sv */
// Purpose: Times one back pressure burst from a duration code.
// Assumes: Start is a one-cycle pulse on the system clock.
// Notes: Durations are exact multiples of the clock period.
`timescale 1ns/1ps
module afc_jam_timer
  import afc_pkg::*;
(
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic start, // Pulse that opens a burst.
  input wire logic [3:0] durCode, // Duration code 0h to Fh.
  input wire logic slowLink, // High at 10 Mb/s.
  input wire logic abort, // Ends a burst at once.
  output logic jamActive // High while the burst lasts.
);
  logic [JAM_CNT_W-1:0] count_reg;
  logic [JAM_CNT_W-1:0] load;

  // Table of burst lengths; 10 Mb/s adds a fixed tail to every code.
  always_comb begin
    unique case (durCode)
      4'h0: load = JAM_CNT_W'(JAM_CYC_0);
      4'h1: load = JAM_CNT_W'(JAM_CYC_1);
      4'h2: load = JAM_CNT_W'(JAM_CYC_2);
      4'h3: load = JAM_CNT_W'(JAM_CYC_3);
      default: load = JAM_CNT_W'(JAM_STEP_CYC * (32'(durCode) - 32'd3));
    endcase
    if (slowLink) begin
      load = load + JAM_CNT_W'(JAM_SLOW_CYC);
    end
  end

  // Counts down; a new start restarts the burst for the next frame.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg <= '0;
    end else if (abort) begin
      count_reg <= '0;
    end else if (start) begin
      count_reg <= load;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - JAM_CNT_W'(1);
    end
  end

  assign jamActive = (count_reg != '0);
endmodule

/* File: hdl/afc_match.sv */
// Purpose: Decides whether a received frame calls for back pressure.
// Assumes: Frame class flags are valid with the start or address strobe.
// Notes: Purely combinational.
`timescale 1ns/1ps
module afc_match
  import afc_pkg::*;
(
  input wire logic [3:0] trigSel, // Trigger bits 3:0 of the config.
  input wire logic preambleSeen, // Valid preamble pulse.
  input wire logic addrSeen, // Destination address decoded pulse.
  input wire logic isMulticast, // Frame is multicast.
  input wire logic isBroadcast, // Frame is broadcast.
  input wire logic isOwnAddress, // Frame is for this station.
  output logic hit // Frame should be jammed.
);
  // The any-frame bit masks the address based triggers entirely.
  always_comb begin
    if (trigSel[ANY_BIT]) begin
      hit = preambleSeen;
    end else begin
      hit = addrSeen & ((trigSel[MCAST_BIT] & isMulticast) |
                        (trigSel[BCAST_BIT] & isBroadcast) |
                        (trigSel[OWN_BIT] & isOwnAddress));
    end
  end
endmodule

/* File: hdl/afc_flow_ctrl.sv */
// Purpose: Automatic receive flow control with pause frames and back pressure.
// Assumes: APB slave, single clock, occupancy counted in bytes by the receive FIFO.
// Notes: The pause frame itself is built by the MAC; this block only requests it.
`timescale 1ns/1ps

// How it works
// - Nothing is requested or jammed while the transmitter is disabled.
// - Bits 23:16 hold the high level in 64-byte units, and flow control fires when occupancy reaches it.
// - In full duplex one pause frame with the configured pause time is requested per high crossing made while the sequencer is idle.
// - In half duplex each matching frame seen while the high level is reached is jammed for the programmed time.
// - Bits 15:8 hold the low level, and falling below it requests a zero-time pause frame.
// - The zero-time frame is only requested after a real pause frame went out for the crossing.
// - Bits 7:4 set the jam length, which full duplex ignores.
// - Bit 3 jams multicast frames once the level is reached, in half duplex only.
// - Bit 2 jams broadcast frames once the level is reached, in half duplex only.
// - Bit 1 jams frames for this station once the level is reached, in half duplex only.
// - Bit 0 acts on any frame, overrides bits 3:1, jams on preamble in half duplex and pauses at once in full.
// - Duration codes give 5, 10, 15, 25 then 50 to 600 us, plus 2.2 us at 10 Mb/s.
// - A pause request is held until the MAC takes it, the transmitter is disabled or bits 3:0 are cleared.
module afc_flow_ctrl
  import afc_pkg::*;
#(
  parameter int unsigned LEVEL_W = 14
) (
  input wire logic clk_sys, // System clock.
  input wire logic sys_rst, // Asynchronous reset, active high.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [11:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  input wire logic [3:0] pstrb, // APB byte strobes.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error for unmapped addresses.
  input wire logic [LEVEL_W-1:0] rxFifoBytes, // Receive data FIFO occupancy in bytes.
  input wire logic txEnabled, // Transmitter enabled.
  input wire logic fullDuplex, // Full duplex mode.
  input wire logic slowLink, // High at 10 Mb/s.
  input wire logic [15:0] pause_time_value, // Pause time from the MAC flow register.
  input wire logic preambleSeen, // Valid preamble pulse.
  input wire logic addrSeen, // Address decoded pulse.
  input wire logic isMulticast, // Frame is multicast.
  input wire logic isBroadcast, // Frame is broadcast.
  input wire logic isOwnAddress, // Frame is for this station.
  input wire logic pauseTaken, // MAC accepted the pause request.
  output logic pauseReq, // Pause frame request, held until taken.
  output logic [15:0] pauseTime, // Pause time for the requested frame.
  output logic backPressure // Jam the incoming frame.
);
  // Fewer than 14 bits cannot hold the top threshold of 255 units of 64 bytes.
  // Above 24 bits the 32-bit scaled comparison would be the only limit, so the range is kept tight.
  if (LEVEL_W < 14 || LEVEL_W > 24) begin : gLevelCheck
    $error("LEVEL_W must lie between 14 and 24");
  end

  logic [31:0] auto_flow_config_reg;
  afc_state_type state_reg;
  logic [15:0] pauseTime_reg;
  logic pauseReq_reg;
  logic backPressure_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic aboveHigh_reg;
  logic jamStart;
  logic jamActive;
  logic matchHit;

  wire logic [7:0] flow_high_level = auto_flow_config_reg[HIGH_MSB:HIGH_LSB];
  wire logic [7:0] flow_low_level = auto_flow_config_reg[LOW_MSB:LOW_LSB];
  wire logic [3:0] jam_duration_code = auto_flow_config_reg[DUR_MSB:DUR_LSB];
  wire logic [3:0] trigSel = auto_flow_config_reg[MCAST_BIT:ANY_BIT];
  wire logic flowEnabled = (trigSel != 4'h0);

  // Thresholds scaled to bytes; occupancy is compared at full width.
  wire logic [31:0] highBytes = 32'(flow_high_level) * 32'(LEVEL_UNIT_BYTES);
  wire logic [31:0] lowBytes = 32'(flow_low_level) * 32'(LEVEL_UNIT_BYTES);
  wire logic reachedHigh = (32'(rxFifoBytes) >= highBytes);
  wire logic belowLow = (32'(rxFifoBytes) < lowBytes);
  wire logic apbAccess = psel & penable & ~pready_reg;
  wire logic hitCfg = (paddr == AUTO_FLOW_CONFIG_OFFSET);
  wire logic hitStatus = (paddr == AFC_STATUS_OFFSET);

  // One wait state: the answer comes one cycle after the access phase opens.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= apbAccess;
      pslverr_reg <= apbAccess & ~(hitCfg | hitStatus);
      if (apbAccess && !pwrite && hitCfg) begin
        prdata_reg <= auto_flow_config_reg;
      end else if (apbAccess && !pwrite && hitStatus) begin
        prdata_reg <= {27'h0, jamActive, pauseReq_reg, state_reg};
      end else begin
        prdata_reg <= 32'h0000_0000;
      end
    end
  end

  // Configuration register with byte strobes; reserved bits 31:24 stay zero.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      auto_flow_config_reg <= CFG_RESET;
    end else if (apbAccess && pwrite && hitCfg) begin
      for (int i = 0; i < 4; i++) begin
        if (pstrb[i]) begin
          auto_flow_config_reg[8*i +: 8] <= pwdata[8*i +: 8] & CFG_WRITE_MASK[8*i +: 8];
        end
      end
    end
  end

  // Previous sample of the high comparison, for crossing detection.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      aboveHigh_reg <= 1'b0;
    end else begin
      aboveHigh_reg <= reachedHigh;
    end
  end

  wire logic highEdge = reachedHigh & ~aboveHigh_reg;
  wire logic canSignal = txEnabled & flowEnabled;

  // Full duplex pause sequencer. HELD means a pause frame went out and waits for release.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= AFC_IDLE;
      pauseReq_reg <= 1'b0;
      pauseTime_reg <= 16'h0000;
    end else if (!flowEnabled) begin
      state_reg <= AFC_IDLE;
      pauseReq_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        AFC_IDLE: begin
          if (pauseReq_reg && pauseTaken) begin
            pauseReq_reg <= 1'b0;
            state_reg <= AFC_HELD;
          end else if (!pauseReq_reg && fullDuplex && txEnabled && highEdge) begin
            pauseReq_reg <= 1'b1;
            pauseTime_reg <= pause_time_value;
          end else if (!txEnabled) begin
            pauseReq_reg <= 1'b0;
          end
        end
        AFC_HELD: begin
          if (belowLow && txEnabled) begin
            pauseReq_reg <= 1'b1;
            pauseTime_reg <= 16'h0000;
            state_reg <= AFC_RELEASE;
          end
        end
        AFC_RELEASE: begin
          if (pauseTaken) begin
            pauseReq_reg <= 1'b0;
            state_reg <= AFC_IDLE;
          end else if (!txEnabled) begin
            pauseReq_reg <= 1'b0;
            state_reg <= AFC_HELD;
          end
        end
      endcase
    end
  end

  // Frame classification for half duplex jamming.
  afc_match u_match (
    .trigSel(trigSel),
    .preambleSeen(preambleSeen),
    .addrSeen(addrSeen),
    .isMulticast(isMulticast),
    .isBroadcast(isBroadcast),
    .isOwnAddress(isOwnAddress),
    .hit(matchHit)
  );

  // Jam each matching frame while the level stays reached; full duplex never jams.
  assign jamStart = canSignal & ~fullDuplex & reachedHigh & matchHit;

  afc_jam_timer u_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .start(jamStart),
    .durCode(jam_duration_code),
    .slowLink(slowLink),
    .abort(~canSignal | fullDuplex),
    .jamActive(jamActive)
  );

  // Registered so the MAC sees a clean level; one cycle behind the timer.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      backPressure_reg <= 1'b0;
    end else begin
      backPressure_reg <= jamActive & canSignal & ~fullDuplex;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign pauseReq = pauseReq_reg;
  assign pauseTime = pauseTime_reg;
  assign backPressure = backPressure_reg;

  // A request while the transmitter is off must be dropped within a cycle.
  no_tx_pause_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !txEnabled |=> !pauseReq_reg)
    else $error("pause requested with transmitter off");

  no_tx_jam_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !txEnabled |=> !backPressure_reg)
    else $error("back pressure with transmitter off");

  sequence crossFd;
    fullDuplex && txEnabled && flowEnabled && highEdge && state_reg == AFC_IDLE && !pauseReq_reg;
  endsequence

  pause_on_high_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    crossFd |=> pauseReq_reg && pauseTime_reg == $past(pause_time_value))
    else $error("missing pause request on high crossing");

  zero_after_pause_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(pauseReq_reg) && pauseTime_reg == 16'h0000 |-> $past(state_reg) == AFC_HELD)
    else $error("zero pause without earlier pause");

  release_low_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    state_reg == AFC_HELD && belowLow && txEnabled && flowEnabled |=> pauseReq_reg && pauseTime_reg == 16'h0000)
    else $error("no zero pause below low level");

  hold_req_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pauseReq_reg && !pauseTaken && txEnabled && flowEnabled |=> pauseReq_reg)
    else $error("pause request dropped before taken");

  jam_half_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    jamStart ##1 (canSignal && !fullDuplex) |=> backPressure_reg)
    else $error("matching frame not jammed");

  fd_no_jam_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fullDuplex ##1 fullDuplex |-> !backPressure_reg)
    else $error("back pressure in full duplex");

  any_override_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    trigSel[ANY_BIT] |-> matchHit == preambleSeen)
    else $error("address trigger fired in any-frame mode");

  // The offered pause time must not move while the MAC has not yet taken the request.
  pause_time_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    pauseReq_reg && !pauseTaken && txEnabled && flowEnabled |=> $stable(pauseTime_reg))
    else $error("pause time changed under a pending request");

  // While held, a fresh crossing is ignored; only the low level or clearing the trigger bits moves the sequencer on.
  sequence heldNoRelease;
    state_reg == AFC_HELD && flowEnabled && !(belowLow && txEnabled);
  endsequence

  held_no_repeat_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    heldNoRelease |=> state_reg == AFC_HELD && !pauseReq_reg)
    else $error("second pause while held");

  // Clearing the trigger bits re-arms the sequencer in idle on the next cycle.
  disable_rearm_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !flowEnabled |=> state_reg == AFC_IDLE && !pauseReq_reg)
    else $error("sequencer not rearmed by disable");

  // Once the zero-time frame is taken, the sequencer waits idle for the next crossing.
  sequence releaseTaken;
    state_reg == AFC_RELEASE && pauseTaken && flowEnabled;
  endsequence

  release_done_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    releaseTaken |=> state_reg == AFC_IDLE && !pauseReq_reg)
    else $error("release frame not retired");

  // Full duplex aborts the timer, so no burst outlives a change of duplex mode.
  fd_timer_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    fullDuplex |=> !jamActive)
    else $error("jam timer running in full duplex");

  // The register bus answers exactly one cycle into the access phase, for one cycle.
  sequence apbOpen;
    psel && penable && !pready_reg;
  endsequence

  apb_wait_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    apbOpen |=> pready_reg ##1 !pready_reg)
    else $error("register bus answer out of step");
endmodule

/* File: sim/afc_link_partner.sv */
// Purpose: Far-side model that accepts pause requests like a busy MAC transmit path.
// Assumes: Requests and answers live on the system clock.
// Notes: Every accepted pause time is logged for the bench to compare.
`timescale 1ns/1ps
module afc_link_partner (
  input wire logic clk_sys, // System clock.
  input wire logic slowAnswer, // Stretch the wait for a transmit window.
  input wire logic pauseReq, // Pause request from the controller.
  input wire logic [15:0] pauseTime, // Pause time offered with the request.
  output logic pauseTaken, // One-cycle acceptance pulse.
  output logic linkPaused // High while the far station holds off.
);
  logic [15:0] pauseLog[$];
  initial begin
    pauseTaken = 1'b0;
    linkPaused = 1'b0;
    // A request waits for the next window, which a busy link makes late.
    forever begin
      @(posedge clk_sys);
      if (pauseReq === 1'b1) begin
        repeat (slowAnswer ? 20 : 2) @(posedge clk_sys);
        // A request withdrawn while waiting is never taken.
        if (pauseReq === 1'b1) begin
          pauseLog.push_back(pauseTime);
          linkPaused <= (pauseTime !== 16'h0000);
          pauseTaken <= 1'b1;
          @(posedge clk_sys);
          pauseTaken <= 1'b0;
          @(posedge clk_sys);
        end
      end
    end
  end
endmodule

/* File: sim/tb_top.sv */
// Purpose: Self-checking bench for the automatic receive flow controller.
// Assumes: APB master of this bench, partner model on the pause handshake.
// Notes: Jam lengths are predicted from integer nanosecond figures.
`timescale 1ns/1ps
module tb_top;
  import afc_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, er, pauseReq, pauseTaken, backPressure, linkPaused;
  logic [13:0] occ = 14'h0;
  logic txEnabled = 1'b1, fullDuplex = 1'b1, slowLink = 1'b0, slowAns = 1'b0;
  logic [15:0] ptv = 16'h0, pauseTime;
  logic preambleSeen = 1'b0, addrSeen = 1'b0, isMc = 1'b0, isBc = 1'b0, isOwn = 1'b0;
  int fail_count = 0, samples_checked = 0, cyc = 0;
  always #2 clk_sys = ~clk_sys;
  afc_flow_ctrl DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxFifoBytes(occ), .txEnabled(txEnabled), .fullDuplex(fullDuplex), .slowLink(slowLink),
    .pause_time_value(ptv), .preambleSeen(preambleSeen), .addrSeen(addrSeen), .isMulticast(isMc),
    .isBroadcast(isBc), .isOwnAddress(isOwn), .pauseTaken(pauseTaken), .pauseReq(pauseReq),
    .pauseTime(pauseTime), .backPressure(backPressure));
  afc_link_partner partner (.clk_sys(clk_sys), .slowAnswer(slowAns), .pauseReq(pauseReq),
    .pauseTime(pauseTime), .pauseTaken(pauseTaken), .linkPaused(linkPaused));
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // The ceiling sits well above the longest jam sequence, so only a hang reaches it.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      results();
    end
  end
  // Request held from setup until pready is sampled high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic waitLog(input int n);
    int k;
    for (k = 0; k < 100 && partner.pauseLog.size() < n; k++) @(posedge clk_sys);
  endtask
  function automatic int expDur(input int code, input bit slw);
    int ns;
    ns = (code == 0) ? 5000 : (code == 1) ? 10000 : (code == 2) ? 15000 : (code == 3) ? 25000 : 50000 * (code - 3);
    return (ns + (slw ? 2200 : 0)) / 4;
  endfunction
  // One frame with the level at occupancy o; the jam length is counted and compared.
  task automatic jam(input logic [3:0] trig, input logic fd, input logic [3:0] code, input logic slw,
      input logic mc, input logic bc, input logic own, input logic tx, input int o);
    int n;
    bit hit;
    hit = tx && !fd && o >= 128 && (trig[0] || (trig[3] && mc) || (trig[2] && bc) || (trig[1] && own));
    apb(1'b1, AUTO_FLOW_CONFIG_OFFSET, {8'h00, 16'h0201, code, trig}, 4'hF);
    @(posedge clk_sys);
    fullDuplex <= fd; slowLink <= slw; txEnabled <= tx; occ <= o[13:0];
    @(posedge clk_sys);
    preambleSeen <= 1'b1;
    @(posedge clk_sys);
    preambleSeen <= 1'b0; addrSeen <= 1'b1; isMc <= mc; isBc <= bc; isOwn <= own;
    @(posedge clk_sys);
    addrSeen <= 1'b0;
    for (n = 0; n < 8 && backPressure !== 1'b1; n++) @(posedge clk_sys);
    for (n = 0; n < 200000 && backPressure === 1'b1; n++) @(posedge clk_sys);
    chk("jamCycles", n, hit ? expDur(code, slw) : 0);
  endtask
  initial begin
    void'($urandom(7));
    // Kept nonzero so the first pause and the release frame can be told apart.
    ptv <= 16'($urandom()) | 16'h0001;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    apb(1'b0, AUTO_FLOW_CONFIG_OFFSET, 32'h0, 4'hF);
    chk("cfgReset", rd, 32'h0);
    chk("mappedOk", er, 1'b0);
    apb(1'b0, AFC_STATUS_OFFSET, 32'h0, 4'hF);
    chk("statusReset", rd, 32'h1);
    apb(1'b1, 12'h0A8, 32'hFFFFFFFF, 4'hF);
    chk("unmappedErr", er, 1'b1);
    apb(1'b1, AUTO_FLOW_CONFIG_OFFSET, 32'hFFFFFFFF, 4'h2);
    apb(1'b0, AUTO_FLOW_CONFIG_OFFSET, 32'h0, 4'hF);
    chk("cfgStrobe", rd, 32'h0000FF00);
    apb(1'b1, AUTO_FLOW_CONFIG_OFFSET, 32'hFF020101, 4'hF);
    apb(1'b0, AUTO_FLOW_CONFIG_OFFSET, 32'h0, 4'hF);
    chk("cfgMask", rd, 32'h00020101);
    // Full duplex: one byte below the threshold, then the threshold itself.
    occ <= 14'd127;
    repeat (10) @(posedge clk_sys);
    chk("belowHigh", partner.pauseLog.size(), 0);
    occ <= 14'd128;
    waitLog(1);
    chk("pauseCount", partner.pauseLog.size(), 1);
    chk("pauseValue", partner.pauseLog[0], ptv);
    apb(1'b0, AFC_STATUS_OFFSET, 32'h0, 4'hF);
    chk("statusHeld", rd, 32'h2);
    chk("linkHeld", linkPaused, 1'b1);
    occ <= 14'd100;
    @(posedge clk_sys);
    occ <= 14'd300;
    repeat (30) @(posedge clk_sys);
    chk("recross", partner.pauseLog.size(), 1);
    slowAns <= 1'b1;
    occ <= 14'd63;
    waitLog(2);
    chk("zeroCount", partner.pauseLog.size(), 2);
    chk("zeroValue", partner.pauseLog[1], 16'h0);
    apb(1'b0, AFC_STATUS_OFFSET, 32'h0, 4'hF);
    chk("statusIdle", rd, 32'h1);
    chk("linkResumed", linkPaused, 1'b0);
    occ <= 14'd10;
    repeat (30) @(posedge clk_sys);
    chk("noSpareZero", partner.pauseLog.size(), 2);
    txEnabled <= 1'b0;
    occ <= 14'd0;
    @(posedge clk_sys);
    occ <= 14'd128;
    repeat (30) @(posedge clk_sys);
    chk("txOffPause", partner.pauseLog.size(), 2);
    // Jam cases: class, level, duplex and transmitter conditions.
    jam(4'h8, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 127);
    jam(4'h8, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 200);
    jam(4'h8, 1'b0, 4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 200);
    jam(4'h4, 1'b0, 4'h1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 200);
    jam(4'h2, 1'b0, 4'h3, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 200);
    jam(4'h2, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 200);
    jam(4'h1, 1'b0, 4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 200);
    jam(4'h8, 1'b0, 4'($urandom_range(4, 0)), 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 200);
    jam(4'h8, 1'b1, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 200);
    jam(4'h8, 1'b0, 4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 200);
    chk("noStrayPause", partner.pauseLog.size(), 2);
    results();
  end
endmodule
